// ==== core/tbs_pkg.sv ====
// Shared constants and types for the boundary-scan test port and its controller
//
// Behaviour
// [RULE1] Sample/preload capture loads all pin levels
// [RULE2] Shift-DR puts scan chain between TDI/TDO
// [RULE3] Update-DR latches shifted pattern onto cell outputs
// [RULE4] Shift out capture while shifting in preload
// [RULE5] Bypass instruction routes TDI through bypass bit
// [RULE6] Cell 89 latched at Update-DR gates outputs
// [RULE7] Latched one drives outputs, zero floats them
// [RULE8] Controller shifts tristate cell, device latches it
// [RULE9] Tristate latch preset at reset and Test-Logic-Reset
// [RULE10] Controller never loads reserved instruction codes
// [RULE11] Test clock kept at or below 20 MHz
// [RULE12] Captured pins may be undefined while changing
// [RULE13] Three-bit instructions: 000, 100, 111; others reserved; code also decodes 001 (IDCODE) and 010 (SAMPLEZ)
// [RULE14] Boundary chain is 89 cells, tristate last
// [RULE15] Inputs sampled on rise, TDO on fall
// [RULE16] Bypass bit cleared when bypass executes
// [RULE17] Standard sixteen-state TAP machine, TMS driven
package tbs_pkg;

  localparam int          IR_W        = 3;
  // [RULE14] chain length, tristate last
  localparam int          BSR_LEN     = 89;
  localparam int          TRI_CELL    = BSR_LEN - 1;
  localparam int          ID_W        = 32;
  localparam int          LEN_W       = 7;
  localparam int          SYNC_STAGES = 3;

  localparam logic [2:0]  IR_EXTEST   = 3'h0;
  localparam logic [2:0]  IR_IDCODE   = 3'h1;
  localparam logic [2:0]  IR_SAMPLEZ  = 3'h2;
  localparam logic [2:0]  IR_SAMPLE   = 3'h4;
  localparam logic [2:0]  IR_BYPASS   = 3'h7;
  localparam logic [2:0]  IR_CAPTURE  = 3'h1;
  localparam logic [2:0]  IR_RSV_A    = 3'h3;
  localparam logic [2:0]  IR_RSV_B    = 3'h5;
  localparam logic [2:0]  IR_RSV_C    = 3'h6;

  // Arbitrary identity value, not taken from any real part
  localparam logic [31:0] ID_VALUE    = 32'h1234_5679;

  // Preset of the update latches: outputs enabled, other cells low
  localparam logic [BSR_LEN-1:0] UPD_RESET = {1'b1, {(BSR_LEN-1){1'b0}}};

  localparam int          MCLK_PERIOD_NS    = 20;
  localparam int          TCK_MIN_PERIOD_NS = 50;
  localparam int          TCK_MIN_HALF_CYC  =
    (TCK_MIN_PERIOD_NS / 2 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  // Controller command kinds
  localparam logic [1:0]  CMD_RESET   = 2'h0;
  localparam logic [1:0]  CMD_IR      = 2'h1;
  localparam logic [1:0]  CMD_DR      = 2'h2;

  // TMS lead-in sequences from Run-Test/Idle, first bit in bit 0
  localparam logic [LEN_W-1:0] PRE_RESET_LEN = 7'h05;
  localparam logic [4:0]       PRE_RESET_PAT = 5'h1F;
  localparam logic [LEN_W-1:0] PRE_IR_LEN    = 7'h04;
  localparam logic [4:0]       PRE_IR_PAT    = 5'h03;
  localparam logic [LEN_W-1:0] PRE_DR_LEN    = 7'h03;
  localparam logic [4:0]       PRE_DR_PAT    = 5'h01;
  localparam logic [LEN_W-1:0] POST_LEN      = 7'h02;

  typedef enum logic [3:0] {
    ST_RESET   = 4'h0,
    ST_IDLE    = 4'h1,
    ST_SEL_DR  = 4'h2,
    ST_CAP_DR  = 4'h3,
    ST_SH_DR   = 4'h4,
    ST_EX1_DR  = 4'h5,
    ST_PAU_DR  = 4'h6,
    ST_EX2_DR  = 4'h7,
    ST_UPD_DR  = 4'h8,
    ST_SEL_IR  = 4'h9,
    ST_CAP_IR  = 4'hA,
    ST_SH_IR   = 4'hB,
    ST_EX1_IR  = 4'hC,
    ST_PAU_IR  = 4'hD,
    ST_EX2_IR  = 4'hE,
    ST_UPD_IR  = 4'hF
  } tbs_tap_state_type;

  // [RULE17] sixteen-state transitions
  function automatic tbs_tap_state_type tbs_tap_next(input tbs_tap_state_type s,
                                                     input logic tms);
    tbs_tap_state_type n;
    n = ST_RESET;
    case (s)
      ST_RESET:  n = tms ? ST_RESET  : ST_IDLE;
      ST_IDLE:   n = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: n = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  n = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: n = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: n = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: n = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: n = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: n = tms ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: n = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  n = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: n = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: n = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: n = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: n = tms ? ST_SEL_DR : ST_IDLE;
      default:   n = ST_RESET;
    endcase
    return n;
  endfunction

  // Instructions that put the boundary chain on the scan path
  function automatic logic tbs_is_bsr(input logic [2:0] ir);
    return (ir == IR_EXTEST) || (ir == IR_SAMPLE) || (ir == IR_SAMPLEZ);
  endfunction

  // [RULE13] reserved codes
  function automatic logic tbs_is_reserved(input logic [2:0] ir);
    return (ir == IR_RSV_A) || (ir == IR_RSV_B) || (ir == IR_RSV_C);
  endfunction

endpackage

// ==== core/tbs_link_if.sv ====
// Four-wire test link between controller and device, with TDO pull-up resolution
`timescale 1ns/100ps
interface tbs_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo_o;
  logic tdo_oe;
  logic tdo;

  // Undriven TDO reads high, as the line is pulled up
  assign tdo = tdo_oe ? tdo_o : 1'b1;

  modport dev (
    input  tck,
    input  tms,
    input  tdi,
    output tdo_o,
    output tdo_oe
  );

  modport ctl (
    output tck,
    output tms,
    output tdi,
    input  tdo
  );
endinterface

// ==== core/tbs_dev.sv ====
// Device end: test access port with boundary chain, bypass, identity and output gating
`timescale 1ns/100ps
module tbs_dev #(
  parameter logic [31:0] ID_CODE = tbs_pkg::ID_VALUE
) (
  // System
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // Link
  tbs_link_if.dev                          link,
  // Pin ring
  input  wire logic [tbs_pkg::BSR_LEN-1:0] pin_level,
  output logic      [tbs_pkg::BSR_LEN-1:0] cell_drive,
  output logic                             extest_mode,
  output logic                             out_bus_oe
);
  import tbs_pkg::*;

  logic [SYNC_STAGES-1:0] tck_s_q;
  logic [SYNC_STAGES-1:0] tms_s_q;
  logic [SYNC_STAGES-1:0] tdi_s_q;
  logic                   tck_lv_q;
  logic                   tms_lv_q;
  logic                   tdi_lv_q;
  logic                   tck_rise;
  logic                   tck_fall;

  tbs_tap_state_type      state_q;
  logic [IR_W-1:0]        ir_q;
  logic [IR_W-1:0]        ir_sh_q;
  logic [BSR_LEN-1:0]     bsr_q;
  logic [BSR_LEN-1:0]     upd_q;
  logic [ID_W-1:0]        id_sh_q;
  logic                   byp_q;
  logic                   tdo_q;
  logic                   tdo_oe_q;
  logic                   extest_q;
  logic                   oe_q;
  logic                   dr_out;

  // Link inputs cross from the controller's clock; a level counts once two stages agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      tck_s_q <= '0;
      tms_s_q <= '1;
      tdi_s_q <= '1;
    end else begin
      tck_s_q <= {tck_s_q[SYNC_STAGES-2:0], link.tck};
      tms_s_q <= {tms_s_q[SYNC_STAGES-2:0], link.tms};
      tdi_s_q <= {tdi_s_q[SYNC_STAGES-2:0], link.tdi};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tck_lv_q <= 1'b0;
      tms_lv_q <= 1'b1;
      tdi_lv_q <= 1'b1;
    end else begin
      if (tck_s_q[1] == tck_s_q[2]) begin
        tck_lv_q <= tck_s_q[2];
      end
      if (tms_s_q[1] == tms_s_q[2]) begin
        tms_lv_q <= tms_s_q[2];
      end
      if (tdi_s_q[1] == tdi_s_q[2]) begin
        tdi_lv_q <= tdi_s_q[2];
      end
    end
  end

  // TMS and TDI pass the same depth as TCK, so they stay aligned with its edges
  assign tck_rise = (tck_s_q[1] == tck_s_q[2]) && tck_s_q[2] && !tck_lv_q;
  assign tck_fall = (tck_s_q[1] == tck_s_q[2]) && !tck_s_q[2] && tck_lv_q;

  // [RULE17] state advance on rise
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_RESET;
    end else if (tck_rise) begin
      state_q <= tbs_tap_next(state_q, tms_lv_q);
    end
  end

  // Instruction path; reserved codes fall back to bypass behaviour
  always_ff @(posedge mclk) begin
    if (rst) begin
      ir_q    <= IR_IDCODE;
      ir_sh_q <= IR_CAPTURE;
    end else if (tck_rise) begin
      case (state_q)
        ST_RESET:  ir_q    <= IR_IDCODE;
        ST_CAP_IR: ir_sh_q <= IR_CAPTURE;
        // [RULE15] TDI taken on rise
        ST_SH_IR:  ir_sh_q <= {tdi_lv_q, ir_sh_q[IR_W-1:1]};
        // [RULE13] decode loaded code
        ST_UPD_IR: ir_q    <= tbs_is_reserved(ir_sh_q) ? IR_BYPASS : ir_sh_q;
        default:   ir_q    <= ir_q;
      endcase
    end
  end

  // Boundary chain shift stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      bsr_q <= '0;
    end else if (tck_rise && tbs_is_bsr(ir_q)) begin
      // [RULE1] capture pin ring
      if (state_q == ST_CAP_DR) begin
        bsr_q <= pin_level;
      end
      // [RULE2] [RULE4] shift out and in
      if (state_q == ST_SH_DR) begin
        bsr_q <= {tdi_lv_q, bsr_q[BSR_LEN-1:1]};
      end
    end
  end

  // Update latches; the top cell is the output-bus tristate control
  always_ff @(posedge mclk) begin
    if (rst) begin
      // [RULE9] preset at power-up
      upd_q <= UPD_RESET;
    end else if (tck_rise) begin
      if (state_q == ST_RESET) begin
        // [RULE9] preset in Test-Logic-Reset
        upd_q[TRI_CELL] <= 1'b1;
      end else if (state_q == ST_UPD_DR && tbs_is_bsr(ir_q)) begin
        // [RULE3] [RULE6] [RULE8] latch at Update-DR
        upd_q <= bsr_q;
      end
    end
  end

  // Bypass bit and identity shifter
  always_ff @(posedge mclk) begin
    if (rst) begin
      byp_q   <= 1'b0;
      id_sh_q <= '0;
    end else if (tck_rise) begin
      if (state_q == ST_CAP_DR) begin
        // [RULE16] bypass cleared
        byp_q   <= 1'b0;
        id_sh_q <= ID_CODE;
      end else if (state_q == ST_SH_DR) begin
        // [RULE5] bypass path
        byp_q   <= tdi_lv_q;
        id_sh_q <= {tdi_lv_q, id_sh_q[ID_W-1:1]};
      end
    end
  end

  always_comb begin
    if (tbs_is_bsr(ir_q)) begin
      dr_out = bsr_q[0];
    end else if (ir_q == IR_IDCODE) begin
      dr_out = id_sh_q[0];
    end else begin
      dr_out = byp_q;
    end
  end

  // [RULE15] TDO changes on fall
  always_ff @(posedge mclk) begin
    if (rst) begin
      tdo_q    <= 1'b1;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      case (state_q)
        ST_SH_DR: begin
          tdo_q    <= dr_out;
          tdo_oe_q <= 1'b1;
        end
        ST_SH_IR: begin
          tdo_q    <= ir_sh_q[0];
          tdo_oe_q <= 1'b1;
        end
        default: begin
          tdo_q    <= 1'b1;
          tdo_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // [RULE6] [RULE7] output bus gating
  always_ff @(posedge mclk) begin
    if (rst) begin
      extest_q <= 1'b0;
      oe_q     <= 1'b1;
    end else begin
      extest_q <= (ir_q == IR_EXTEST);
      if (ir_q == IR_EXTEST) begin
        oe_q <= upd_q[TRI_CELL];
      end else begin
        oe_q <= (ir_q != IR_SAMPLEZ);
      end
    end
  end

  assign link.tdo_o   = tdo_q;
  assign link.tdo_oe  = tdo_oe_q;
  assign cell_drive   = upd_q;
  assign extest_mode  = extest_q;
  assign out_bus_oe   = oe_q;

endmodule

// ==== core/tbs_ctl.sv ====
// Controller end: makes the test clock and runs reset, instruction and data scans
`timescale 1ns/100ps
module tbs_ctl #(
  parameter int HALF_CYC = 10
) (
  // System
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // Link
  tbs_link_if.ctl                          link,
  // Command
  input  wire logic                        cmd_valid,
  input  wire logic [1:0]                  cmd_kind,
  input  wire logic [tbs_pkg::IR_W-1:0]    cmd_ir,
  input  wire logic [tbs_pkg::LEN_W-1:0]   cmd_len,
  input  wire logic [tbs_pkg::BSR_LEN-1:0] cmd_data,
  // Answer
  output logic                             busy,
  output logic                             done,
  output logic                             refused,
  output logic      [tbs_pkg::BSR_LEN-1:0] rsp_data
);
  import tbs_pkg::*;

  localparam int HALF = (HALF_CYC < TCK_MIN_HALF_CYC) ? TCK_MIN_HALF_CYC : HALF_CYC;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_LOW  = 2'h1,
    H_HIGH = 2'h2
  } tbs_ctl_state_type;

  tbs_ctl_state_type      st_q;
  logic [7:0]             cnt_q;
  logic [LEN_W-1:0]       slot_q;
  logic [LEN_W-1:0]       pre_len_q;
  logic [4:0]             pre_pat_q;
  logic [LEN_W-1:0]       sh_len_q;
  logic [BSR_LEN-1:0]     tx_q;
  logic [BSR_LEN-1:0]     rx_q;
  logic [SYNC_STAGES-1:0] tdo_s_q;
  logic                   tdo_lv_q;
  logic                   tck_q;
  logic                   tms_q;
  logic                   tdi_q;
  logic                   busy_q;
  logic                   done_q;
  logic                   refused_q;
  logic                   in_shift;
  logic                   last_slot;
  logic                   slot_tms;
  logic [LEN_W-1:0]       sh_end;

  assign sh_end    = pre_len_q + sh_len_q;
  assign in_shift  = (slot_q >= pre_len_q) && (slot_q < sh_end);
  assign last_slot = (slot_q == sh_end + POST_LEN - 7'h01);

  always_comb begin
    if (slot_q < pre_len_q) begin
      slot_tms = pre_pat_q[slot_q[2:0]];
    end else if (in_shift) begin
      slot_tms = (slot_q == sh_end - 7'h01);
    end else begin
      slot_tms = (slot_q == sh_end);
    end
  end

  // TDO crosses from the device clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      tdo_s_q  <= '1;
      tdo_lv_q <= 1'b1;
    end else begin
      tdo_s_q <= {tdo_s_q[SYNC_STAGES-2:0], link.tdo};
      if (tdo_s_q[1] == tdo_s_q[2]) begin
        tdo_lv_q <= tdo_s_q[2];
      end
    end
  end

  // [RULE11] divided test clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q   <= H_IDLE;
      cnt_q  <= '0;
      slot_q <= '0;
      tck_q  <= 1'b0;
    end else begin
      case (st_q)
        H_IDLE: begin
          tck_q  <= 1'b0;
          slot_q <= '0;
          cnt_q  <= '0;
          if (cmd_valid) begin
            st_q <= H_LOW;
          end
        end
        H_LOW: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(HALF - 1)) begin
            cnt_q <= '0;
            tck_q <= 1'b1;
            st_q  <= H_HIGH;
          end
        end
        H_HIGH: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == 8'(HALF - 1)) begin
            cnt_q  <= '0;
            tck_q  <= 1'b0;
            slot_q <= slot_q + 7'h01;
            st_q   <= last_slot ? H_IDLE : H_LOW;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // Command capture and per-slot TMS/TDI; data moves LSB first
  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_len_q <= '0;
      pre_pat_q <= '0;
      sh_len_q  <= '0;
      tx_q      <= '0;
      tms_q     <= 1'b1;
      tdi_q     <= 1'b1;
    end else if (st_q == H_IDLE && cmd_valid) begin
      tx_q <= cmd_data;
      case (cmd_kind)
        CMD_IR: begin
          pre_len_q <= PRE_IR_LEN;
          pre_pat_q <= PRE_IR_PAT;
          sh_len_q  <= 7'(IR_W);
          // [RULE10] reserved codes replaced by bypass
          tx_q      <= {{(BSR_LEN-IR_W){1'b0}},
                        tbs_is_reserved(cmd_ir) ? IR_BYPASS : cmd_ir};
        end
        CMD_DR: begin
          pre_len_q <= PRE_DR_LEN;
          pre_pat_q <= PRE_DR_PAT;
          sh_len_q  <= (cmd_len > 7'(BSR_LEN)) ? 7'(BSR_LEN) : cmd_len;
        end
        default: begin
          pre_len_q <= PRE_RESET_LEN;
          pre_pat_q <= PRE_RESET_PAT;
          sh_len_q  <= '0;
        end
      endcase
    end else if (st_q == H_LOW && cnt_q == 8'h00) begin
      // Drive only in the low phase so the device sees stable levels at the rise
      tms_q <= slot_tms;
      tdi_q <= in_shift ? tx_q[0] : 1'b1;
      if (in_shift) begin
        tx_q <= {1'b0, tx_q[BSR_LEN-1:1]};
      end
    end
  end

  // Sample TDO at the end of the low phase, just before the rise
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_q <= '0;
    end else if (st_q == H_IDLE && cmd_valid) begin
      rx_q <= '0;
    end else if (st_q == H_LOW && cnt_q == 8'(HALF - 1) && in_shift) begin
      rx_q <= {tdo_lv_q, rx_q[BSR_LEN-1:1]};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      done_q    <= (st_q == H_HIGH) && (cnt_q == 8'(HALF - 1)) && last_slot;
      refused_q <= (st_q == H_IDLE) && cmd_valid && (cmd_kind == CMD_IR)
                   && tbs_is_reserved(cmd_ir);
      if (st_q == H_IDLE && cmd_valid) begin
        busy_q <= 1'b1;
      end else if (st_q == H_HIGH && cnt_q == 8'(HALF - 1) && last_slot) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign link.tck = tck_q;
  assign link.tms = tms_q;
  assign link.tdi = tdi_q;
  assign busy     = busy_q;
  assign done     = done_q;
  assign refused  = refused_q;
  assign rsp_data = rx_q;

endmodule

// ==== dv/tbs_link_checker.sv ====
// Link-level assertions for the four-wire test port
`timescale 1ns/100ps
module tbs_link_checker (
  // System
  input wire logic mclk,
  input wire logic rst,
  // Link
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo_o,
  input wire logic tdo_oe,
  input wire logic tdo
);
  logic [2:0] hi_cnt_q;
  logic [3:0] fall_cnt_q;
  logic       last_tms_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Counts rises with TMS high; five of them reach Test-Logic-Reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      hi_cnt_q   <= 3'h0;
      last_tms_q <= 1'b1;
    end else if ($rose(tck)) begin
      last_tms_q <= tms;
      hi_cnt_q   <= !tms ? 3'h0 : (hi_cnt_q == 3'h7 ? 3'h7 : hi_cnt_q + 3'h1);
    end
  end

  // Saturating age of the last falling test-clock edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      fall_cnt_q <= 4'hF;
    end else if ($fell(tck)) begin
      fall_cnt_q <= 4'h0;
    end else if (fall_cnt_q != 4'hF) begin
      fall_cnt_q <= fall_cnt_q + 4'h1;
    end
  end

  sequence s_rise;
    $rose(tck);
  endsequence
  sequence s_fall;
    $fell(tck);
  endsequence
  sequence s_tdo_move;
    $changed(tdo_o) || $changed(tdo_oe);
  endsequence

  tck_low_min_a: assert property (s_fall |-> !tck [*8])
    else $error("test clock low phase too short");
  tck_high_min_a: assert property (s_rise |-> tck [*8])
    else $error("test clock high phase too short");
  tms_hold_a: assert property (s_rise |-> $stable(tms) ##1 $stable(tms) [*6])
    else $error("mode select moved around a rise");
  tdi_hold_a: assert property (s_rise |-> $stable(tdi) ##1 $stable(tdi) [*6])
    else $error("data in moved around a rise");
  tdo_low_phase_a: assert property ($changed(tdo_o) |-> !tck)
    else $error("data out moved while test clock high");
  tdo_delay_a: assert property (s_tdo_move |-> fall_cnt_q inside {[1:7]})
    else $error("data out not launched from a falling edge");
  shift_enter_a: assert property ($rose(tdo_oe) |-> !last_tms_q && !tck)
    else $error("data out enabled outside a shift");
  reset_float_a: assert property (hi_cnt_q >= 3'h5 |-> !tdo_oe && tdo)
    else $error("data out driven in test-logic reset");
endmodule

// ==== dv/test_tap_boundary_scan_instructions.sv ====
// Self-checking bench: controller and device joined by the test link
`timescale 1ns/100ps
module test_tap_boundary_scan_instructions;
  import tbs_pkg::*;
  localparam logic [BSR_LEN-1:0] ALL_ONES = {BSR_LEN{1'b1}};
  // Bypass first, then the three reserved codes, lowest slice first
  localparam logic [11:0]        CODES    = {3'h6, 3'h5, 3'h3, 3'h7};
  logic                 mclk      = 1'b0;
  logic                 rst       = 1'b1;
  logic                 cmd_valid = 1'b0;
  logic [1:0]           cmd_kind  = CMD_RESET;
  logic [IR_W-1:0]      cmd_ir    = IR_BYPASS;
  logic [LEN_W-1:0]     cmd_len   = 7'h00;
  logic [BSR_LEN-1:0]   cmd_data  = 89'h0;
  logic [BSR_LEN-1:0]   pin_level = 89'h0;
  logic [15:0]          lfsr_q    = 16'h0010;
  logic                 busy;
  logic                 done;
  logic                 refused;
  logic                 extest_mode;
  logic                 out_bus_oe;
  logic                 ref_seen  = 1'b0;
  logic [BSR_LEN-1:0]   rsp_data;
  logic [BSR_LEN-1:0]   cell_drive;
  logic [2*BSR_LEN-1:0] note;
  logic [2*BSR_LEN-1:0] exp_q [$];
  int                   n_fail    = 0;
  int                   cmp_count = 0;

  always #10 mclk = ~mclk;

  tbs_link_if link ();
  tbs_dev i_tbs_dev (.mclk(mclk), .rst(rst), .link(link), .pin_level(pin_level),
                     .cell_drive(cell_drive), .extest_mode(extest_mode),
                     .out_bus_oe(out_bus_oe));
  tbs_ctl #(.HALF_CYC(10)) i_tbs_ctl (.mclk(mclk), .rst(rst), .link(link),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_ir(cmd_ir), .cmd_len(cmd_len),
    .cmd_data(cmd_data), .busy(busy), .done(done), .refused(refused), .rsp_data(rsp_data));
  tbs_link_checker i_tbs_link_checker (.mclk(mclk), .rst(rst), .tck(link.tck),
    .tms(link.tms), .tdi(link.tdi), .tdo_o(link.tdo_o), .tdo_oe(link.tdo_oe), .tdo(link.tdo));

  task automatic cmp_v(input logic [BSR_LEN-1:0] got, input logic [BSR_LEN-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_b(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic logic [BSR_LEN-1:0] rnd89();
    logic [BSR_LEN-1:0] v;
    v = 89'h0;
    for (int i = 0; i < 6; i++) begin
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      v = {v[72:0], lfsr_q};
    end
    return v;
  endfunction

  // Notes the masked expectation, then hands one command over and waits for done
  task automatic run(input logic [1:0] k, input logic [2:0] ir, input logic [6:0] len,
                     input logic [BSR_LEN-1:0] d, input logic [BSR_LEN-1:0] e,
                     input logic [BSR_LEN-1:0] m);
    int n;
    exp_q.push_back({e, m});
    @(negedge mclk);
    cmd_kind  = k;
    cmd_ir    = ir;
    cmd_len   = len;
    cmd_data  = d;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmp_b(busy, 1'b1);
    n = 0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 4000) begin
      n_fail++;
    end
    // Output enable lags the latches by a cycle, so settle before looking
    repeat (2) @(negedge mclk);
    cmp_b(busy, 1'b0);
  endtask

  // Pulses are looked at mid-cycle, away from the edge that launches them
  always @(negedge mclk) begin
    if (refused === 1'b1) begin
      ref_seen = 1'b1;
    end
  end

  // A result without a queued note is forced to mismatch
  always @(negedge mclk) begin
    if (done === 1'b1) begin
      note = (exp_q.size() != 0) ? exp_q.pop_front() : {~rsp_data, ALL_ONES};
      cmp_v(rsp_data & note[88:0], note[177:89] & note[88:0]);
    end
  end

  initial begin
    repeat (40000) @(posedge mclk);
    n_fail++;
    close_out();
  end

  initial begin
    logic [BSR_LEN-1:0] d;
    logic [BSR_LEN-1:0] p;
    logic [IR_W-1:0]    code;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    run(CMD_RESET, IR_BYPASS, 7'h00, 89'h0, 89'h0, 89'h0);
    cmp_b(cell_drive[TRI_CELL], 1'b1);
    cmp_b(out_bus_oe, 1'b1);
    run(CMD_DR, IR_IDCODE, 7'h20, 89'h0, {ID_VALUE, 57'h0}, {32'hFFFFFFFF, 57'h0});
    run(CMD_IR, IR_SAMPLE, 7'h00, 89'h0, 89'h0, 89'h0);
    for (int i = 0; i < 2; i++) begin
      p = rnd89();
      d = rnd89();
      d[TRI_CELL] = i[0];
      @(negedge mclk);
      pin_level = p;
      run(CMD_DR, IR_SAMPLE, 7'h59, d, p, ALL_ONES);
      cmp_v(cell_drive, d);
      cmp_b(out_bus_oe, 1'b1);
    end
    run(CMD_IR, IR_EXTEST, 7'h00, 89'h0, 89'h0, 89'h0);
    cmp_b(extest_mode, 1'b1);
    cmp_b(out_bus_oe, 1'b1);
    for (int b = 0; b < 3; b++) begin
      d = rnd89();
      d[TRI_CELL] = (b == 1);
      run(CMD_DR, IR_EXTEST, 7'h59, d, pin_level, ALL_ONES);
      cmp_v(cell_drive, d);
      cmp_b(out_bus_oe, d[TRI_CELL]);
    end
    run(CMD_IR, IR_SAMPLEZ, 7'h00, 89'h0, 89'h0, 89'h0);
    cmp_b(extest_mode, 1'b0);
    cmp_b(out_bus_oe, 1'b0);
    run(CMD_RESET, IR_BYPASS, 7'h00, 89'h0, 89'h0, 89'h0);
    cmp_b(cell_drive[TRI_CELL], 1'b1);
    cmp_b(extest_mode, 1'b0);
    cmp_b(out_bus_oe, 1'b1);
    for (int c = 0; c < 4; c++) begin
      ref_seen = 1'b0;
      code = CODES[3*c +: 3];
      run(CMD_IR, code, 7'h00, 89'h0, 89'h0, 89'h0);
      cmp_b(ref_seen, code != IR_BYPASS);
      d = rnd89();
      run(CMD_DR, code, 7'h08, d, {d[6:0], 1'b0, 81'h0}, {8'hFF, 81'h0});
    end
    close_out();
  end
endmodule
